// [rtl/mas_pkg.sv]
// constants, map indices and link states for the map address select block
package mas_pkg;

  localparam int MAP_COUNT = 8;
  localparam int ADDR_BITS = 7;

  // control map bus addresses in 8-bit write form
  localparam logic [7:0] CTRL_ADDR_DEFAULT = 8'h98;
  localparam logic [7:0] CTRL_ADDR_ALT = 8'h9a;
  localparam logic CTRL_LOW_BIT_RESET = 1'b0;

  localparam logic [6:0] MAP_ADDR_DISABLED = 7'h00;
  localparam logic [6:0] MAP_ADDR_RESET = 7'h00;

  // control map subaddresses
  localparam logic [7:0] SUB_STRAP_SAMPLE = 8'h1b;
  localparam logic [7:0] SUB_CONSUMER_CTRL = 8'hf4;
  localparam logic [7:0] SUB_PACKET_INFO = 8'hf5;
  localparam logic [7:0] SUB_CLOCK_SYNTH = 8'hf8;
  localparam logic [7:0] SUB_REPEATER = 8'hf9;
  localparam logic [7:0] SUB_DISPLAY_ID = 8'hfa;
  localparam logic [7:0] SUB_RECEIVER_CORE = 8'hfb;
  localparam logic [7:0] SUB_COMPONENT_PROC = 8'hfd;
  localparam logic [7:0] SUB_LAST = 8'hff;
  localparam logic [7:0] SUB_RESET = 8'h00;

  localparam int STRAP_TRIGGER_BIT = 0;
  localparam int ADDR_FIELD_LSB = 1;
  localparam logic STRAP_TRIGGER_RESET = 1'b0;

  // bit slots inside one nine-clock byte frame
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] FIRST_BIT_DONE = 4'h1;

  typedef enum logic [2:0] {
    MAP_CONTROL,
    MAP_CONSUMER_CTRL,
    MAP_PACKET_INFO,
    MAP_CLOCK_SYNTH,
    MAP_REPEATER,
    MAP_DISPLAY_ID,
    MAP_RECEIVER_CORE,
    MAP_COMPONENT_PROC
  } mas_map_e;

  // subaddress that holds each programmable map's address, by map index
  localparam logic [7:0] MAP_SUB_OFS [MAP_COUNT] = '{
    SUB_STRAP_SAMPLE, SUB_CONSUMER_CTRL, SUB_PACKET_INFO, SUB_CLOCK_SYNTH,
    SUB_REPEATER, SUB_DISPLAY_ID, SUB_RECEIVER_CORE, SUB_COMPONENT_PROC
  };

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_WDATA,
    ST_RDATA
  } mas_state_e;

  // width of the configuration word mirrored into the link domain
  localparam int CFG_WIDTH = 2 + (MAP_COUNT - 1) * ADDR_BITS;

endpackage

// [rtl/mas_sync.sv]
// two-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps
module mas_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end

endmodule

// [rtl/mas_addr_select.sv]
// slave address decode and control map registers for the main two-wire port
`timescale 1ns/1ps
module mas_addr_select (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic VSYNC_STRAP_PIN,
  output logic CONTROL_ADDR_LOW_BIT,
  output logic [mas_pkg::MAP_COUNT-1:0] MAP_ENABLED,
  output logic MAP_WR_STB,
  output mas_pkg::mas_map_e MAP_WR_SEL,
  output logic [7:0] MAP_WR_SUBADDR,
  output logic [7:0] MAP_WR_DATA
);
  import mas_pkg::*;

  // ---------------- system clock domain ----------------
  logic strap_sync;
  logic strap_trigger;
  logic [6:0] map_addr [MAP_COUNT];
  logic wr_tog_sync;
  logic wr_tog_prev;
  logic sys_wr_evt;
  logic sys_ctrl_wr;
  logic [CFG_WIDTH-1:0] cfg_sys;

  // ---------------- link (serial clock) domain ----------------
  logic start_tog;
  logic stop_tog;
  logic start_seen;
  logic stop_seen;
  logic start_pend;
  logic stop_pend;
  mas_state_e state;
  logic [3:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] rx_byte;
  mas_map_e cur_map;
  logic rw;
  logic ack_ok;
  logic [7:0] sub_ptr;
  logic past_end;
  logic [7:0] rd_byte;
  logic [7:0] rd_value;
  logic [3:0] tx_idx;
  logic byte_done;
  logic ack_rise;
  logic wdata_ok;
  logic link_wr_tog;
  mas_map_e link_wr_map;
  logic [7:0] link_wr_sub;
  logic [7:0] link_wr_data;
  logic [CFG_WIDTH-1:0] cfg_link;
  logic link_trigger;
  logic link_low_bit;
  logic [6:0] link_addr [MAP_COUNT];
  logic [6:0] ctrl7;
  logic hit;
  mas_map_e hit_map;

  // subaddresses the control map implements; every other map takes all 256
  function automatic logic sub_valid(input mas_map_e map, input logic [7:0] sub);
    logic ok;
    ok = (map != MAP_CONTROL);
    for (int i = 0; i < MAP_COUNT; i++) begin
      if (sub == MAP_SUB_OFS[i]) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  // ================= system clock side =================

  // strap pin comes from outside, two flops before use
  mas_sync #(.WIDTH(1)) u_strap_sync (
    .clk(SYS_CLK),
    .d(VSYNC_STRAP_PIN),
    .q(strap_sync)
  );

  // write events arrive as a toggle; the word beside it is held for a whole byte
  mas_sync #(.WIDTH(1)) u_wr_sync (
    .clk(SYS_CLK),
    .d(link_wr_tog),
    .q(wr_tog_sync)
  );

  assign sys_wr_evt = wr_tog_sync ^ wr_tog_prev;
  assign sys_ctrl_wr = sys_wr_evt && (link_wr_map == MAP_CONTROL);

  // edge memory for the write toggle
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      wr_tog_prev <= 1'b0;
    end else begin
      wr_tog_prev <= wr_tog_sync;
    end
  end

  // strap sample control, a plain level bit
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      strap_trigger <= STRAP_TRIGGER_RESET;
    end else if (sys_ctrl_wr && link_wr_sub == SUB_STRAP_SAMPLE) begin
      strap_trigger <= link_wr_data[STRAP_TRIGGER_BIT];
    end
  end

  // stored strap bit; resampled every cycle only while the trigger is high
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      CONTROL_ADDR_LOW_BIT <= CTRL_LOW_BIT_RESET;
    end else if (strap_trigger) begin
      CONTROL_ADDR_LOW_BIT <= strap_sync;
    end
  end
  // trigger low: the stored bit simply holds

  // control map has no address register, it is always reachable
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      MAP_ENABLED[0] <= 1'b0;
    end else begin
      MAP_ENABLED[0] <= 1'b1;
    end
  end
  assign map_addr[0] = MAP_ADDR_DISABLED;

  // one address register per programmable map, bits 7:1 of its control byte
  for (genvar g = 1; g < MAP_COUNT; g++) begin : g_map_reg
    always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
        map_addr[g] <= MAP_ADDR_RESET;
      end else if (sys_ctrl_wr && link_wr_sub == MAP_SUB_OFS[g]) begin
        map_addr[g] <= link_wr_data[7:ADDR_FIELD_LSB];
      end
    end

    always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
        MAP_ENABLED[g] <= 1'b0;
      end else begin
        MAP_ENABLED[g] <= (map_addr[g] != MAP_ADDR_DISABLED);
      end
    end

    assign cfg_sys[(g-1)*ADDR_BITS +: ADDR_BITS] = map_addr[g];
    assign link_addr[g] = cfg_link[(g-1)*ADDR_BITS +: ADDR_BITS];
  end

  assign cfg_sys[CFG_WIDTH-1] = strap_trigger;
  assign cfg_sys[CFG_WIDTH-2] = CONTROL_ADDR_LOW_BIT;

  // writes for the other maps leave as a one-cycle strobe with their word;
  // control map writes stay inside, so the outgoing word moves only with a strobe
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      MAP_WR_STB <= 1'b0;
      MAP_WR_SEL <= MAP_CONTROL;
      MAP_WR_SUBADDR <= SUB_RESET;
      MAP_WR_DATA <= 8'h00;
    end else begin
      MAP_WR_STB <= sys_wr_evt && (link_wr_map != MAP_CONTROL);
      if (sys_wr_evt && link_wr_map != MAP_CONTROL) begin
        MAP_WR_SEL <= link_wr_map;
        MAP_WR_SUBADDR <= link_wr_sub;
        MAP_WR_DATA <= link_wr_data;
      end
    end
  end

  // ================= serial clock side =================

  // configuration changes only on control map writes and, while the trigger is high, with the strap pin, so a word-wide sync is safe
  mas_sync #(.WIDTH(CFG_WIDTH)) u_cfg_sync (
    .clk(SCL),
    .d(cfg_sys),
    .q(cfg_link)
  );

  assign link_trigger = cfg_link[CFG_WIDTH-1];
  assign link_low_bit = cfg_link[CFG_WIDTH-2];
  assign link_addr[0] = MAP_ADDR_DISABLED;
  assign ctrl7 = {CTRL_ADDR_DEFAULT[7:2], link_low_bit};

  // start: data falls while clock high; sda edges are the only way to see it
  always_ff @(negedge SDA_I or negedge NRST) begin
    if (!NRST) begin
      start_tog <= 1'b0;
    end else if (SCL) begin
      start_tog <= ~start_tog;
    end
  end

  // stop: data rises while clock high
  always_ff @(posedge SDA_I or negedge NRST) begin
    if (!NRST) begin
      stop_tog <= 1'b0;
    end else if (SCL) begin
      stop_tog <= ~stop_tog;
    end
  end

  assign start_pend = start_tog ^ start_seen;
  assign stop_pend = stop_tog ^ stop_seen;
  // seven bits already shifted plus the bit on this edge make the whole byte
  assign rx_byte = {shreg, SDA_I};

  // slave address match; control first, disabled maps never match
  always_comb begin
    hit = 1'b0;
    hit_map = MAP_CONTROL;
    if (rx_byte[7:1] == ctrl7) begin
      hit = 1'b1;
    end else begin
      for (int i = 1; i < MAP_COUNT; i++) begin
        if (!hit && link_addr[i] != MAP_ADDR_DISABLED && rx_byte[7:1] == link_addr[i]) begin
          hit = 1'b1;
          hit_map = mas_map_e'(3'(i));
        end
      end
    end
  end

  // readback of the control map; unimplemented bytes read zero
  always_comb begin
    rd_value = 8'h00;
    if (cur_map == MAP_CONTROL) begin
      if (sub_ptr == SUB_STRAP_SAMPLE) begin
        rd_value = {7'h00, link_trigger};
      end
      for (int i = 1; i < MAP_COUNT; i++) begin
        if (sub_ptr == MAP_SUB_OFS[i]) begin
          rd_value = {link_addr[i], 1'b0};
        end
      end
    end
  end

  assign byte_done = (state != ST_IDLE) && !start_pend && !stop_pend && bit_cnt == LAST_DATA_BIT;
  assign ack_rise = (state != ST_IDLE) && !start_pend && !stop_pend && bit_cnt == ACK_SLOT;
  assign wdata_ok = !past_end && sub_valid(cur_map, sub_ptr);

  // frame sequencer: address, subaddress, then data bytes
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
      bit_cnt <= BIT_CNT_RESET;
      shreg <= 7'h00;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else if (start_pend) begin
      // this rising edge already carries the first address bit
      start_seen <= start_tog;
      stop_seen <= stop_tog;
      state <= ST_ADDR;
      bit_cnt <= FIRST_BIT_DONE;
      shreg <= {6'h00, SDA_I};
    end else if (stop_pend) begin
      stop_seen <= stop_tog;
      state <= ST_IDLE;
      bit_cnt <= BIT_CNT_RESET;
    end else if (state != ST_IDLE) begin
      if (bit_cnt != ACK_SLOT) begin
        shreg <= {shreg[5:0], SDA_I};
        bit_cnt <= bit_cnt + 4'h1;
      end else begin
        bit_cnt <= BIT_CNT_RESET;
        unique case (state)
          ST_ADDR: state <= !ack_ok ? ST_IDLE : (rw ? ST_RDATA : ST_SUB);
          ST_SUB: state <= ack_ok ? ST_WDATA : ST_IDLE;
          ST_WDATA: state <= ack_ok ? ST_WDATA : ST_IDLE;
          ST_RDATA: state <= SDA_I ? ST_IDLE : ST_RDATA;
          ST_IDLE: state <= ST_IDLE;
        endcase
      end
    end
  end

  // byte decisions taken on the eighth data bit
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      cur_map <= MAP_CONTROL;
      rw <= 1'b0;
      ack_ok <= 1'b0;
    end else if (start_pend) begin
      ack_ok <= 1'b0;
    end else if (byte_done) begin
      unique case (state)
        ST_ADDR: begin
          cur_map <= hit_map;
          rw <= rx_byte[0];
          ack_ok <= hit;
        end
        ST_SUB: ack_ok <= sub_valid(cur_map, rx_byte);
        ST_WDATA: ack_ok <= wdata_ok;
        default: ack_ok <= 1'b0;
      endcase
    end
  end

  // subaddress pointer survives between transfers for current-address reads
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      sub_ptr <= SUB_RESET;
      past_end <= 1'b0;
      rd_byte <= 8'h00;
    end else if (byte_done && state == ST_SUB) begin
      sub_ptr <= rx_byte;
      past_end <= 1'b0;
    end else if (byte_done && state == ST_WDATA && wdata_ok) begin
      // a write beyond the last byte is dropped and refused
      past_end <= (sub_ptr == SUB_LAST);
      sub_ptr <= (sub_ptr == SUB_LAST) ? sub_ptr : sub_ptr + 8'h01;
    end else if (ack_rise && ((state == ST_ADDR && ack_ok && rw) ||
                              (state == ST_RDATA && !SDA_I))) begin
      // reads past the top keep repeating the last byte
      rd_byte <= rd_value;
      sub_ptr <= (sub_ptr == SUB_LAST) ? sub_ptr : sub_ptr + 8'h01;
    end
  end

  // accepted data bytes are handed to the system side
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      link_wr_tog <= 1'b0;
      link_wr_map <= MAP_CONTROL;
      link_wr_sub <= SUB_RESET;
      link_wr_data <= 8'h00;
    end else if (byte_done && state == ST_WDATA && wdata_ok) begin
      link_wr_tog <= ~link_wr_tog;
      link_wr_map <= cur_map;
      link_wr_sub <= sub_ptr;
      link_wr_data <= rx_byte;
    end
  end

  assign tx_idx = LAST_DATA_BIT - bit_cnt;

  // data line changes only while the clock is low
  always_ff @(negedge SCL or negedge NRST) begin
    if (!NRST) begin
      SDA_OE <= 1'b0;
    end else if (start_pend || stop_pend || state == ST_IDLE) begin
      SDA_OE <= 1'b0;
    end else if (bit_cnt == ACK_SLOT) begin
      SDA_OE <= (state != ST_RDATA) && ack_ok;
    end else if (state == ST_RDATA) begin
      SDA_OE <= ~rd_byte[tx_idx[2:0]];
    end else begin
      SDA_OE <= 1'b0;
    end
  end

  // open-drain: the driven level is always low
  always_ff @(negedge SCL or negedge NRST) begin
    if (!NRST) begin
      SDA_O <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
    end
  end

endmodule

// [testbench/mas_addr_select_sva.sv]
// assertions on the map address select ports
`timescale 1ns/1ps
module mas_addr_select_sva (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic VSYNC_STRAP_PIN,
  input wire logic CONTROL_ADDR_LOW_BIT,
  input wire logic [mas_pkg::MAP_COUNT-1:0] MAP_ENABLED,
  input wire logic MAP_WR_STB,
  input wire mas_pkg::mas_map_e MAP_WR_SEL,
  input wire logic [7:0] MAP_WR_SUBADDR,
  input wire logic [7:0] MAP_WR_DATA
);
  import mas_pkg::*;
  // everything here is judged on the system clock
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // only the control map answers right after reset
  property p_rst_map;
    $rose(NRST) |=> MAP_ENABLED == 8'h01;
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("map enables wrong after reset");
  // control map can never be switched off
  property p_ctrl_on;
    $past(NRST) |-> MAP_ENABLED[0];
  endproperty
  a_ctrl_on: assert property (p_ctrl_on) else $error("control map disabled");
  // stored strap bit only moves to a recently synchronised pin level
  property p_strap;
    $changed(CONTROL_ADDR_LOW_BIT) |-> (CONTROL_ADDR_LOW_BIT == $past(VSYNC_STRAP_PIN, 2))
      || (CONTROL_ADDR_LOW_BIT == $past(VSYNC_STRAP_PIN, 3))
      || (CONTROL_ADDR_LOW_BIT == $past(VSYNC_STRAP_PIN, 4));
  endproperty
  a_strap: assert property (p_strap) else $error("strap bit took a stale pin level");
  // control map writes stay internal, never strobed out
  property p_stb_not_ctrl;
    MAP_WR_STB |-> MAP_WR_SEL != MAP_CONTROL;
  endproperty
  a_stb_not_ctrl: assert property (p_stb_not_ctrl) else $error("strobe for control map");
  property p_stb_enabled;
    MAP_WR_STB |-> MAP_ENABLED[MAP_WR_SEL];
  endproperty
  a_stb_enabled: assert property (p_stb_enabled) else $error("write to disabled map");
  // each strobe is a single-cycle pulse
  property p_stb_pulse;
    MAP_WR_STB |=> !MAP_WR_STB;
  endproperty
  a_stb_pulse: assert property (p_stb_pulse) else $error("strobe longer than a cycle");
  // write fields only move together with a strobe
  property p_wr_hold;
    $past(NRST) && ($changed(MAP_WR_DATA) || $changed(MAP_WR_SUBADDR)) |-> ##[0:1] MAP_WR_STB;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write fields moved without strobe");
  // open drain: driven value is always low
  property p_sda_low;
    SDA_O == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data line driven high");
  c_stb: cover property (MAP_WR_STB);
  c_low: cover property ($rose(CONTROL_ADDR_LOW_BIT));
  c_ack: cover property ($rose(SDA_OE));
endmodule

// [testbench/mas_i2c_master.sv]
// two-wire bus master model for the configuration port
`timescale 1ns/1ps
module mas_i2c_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // released bus; clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // start or repeated start: data falls while clock high
  task start();
    sda_m = 1'b1;
    #30 scl = 1'b1;
    #30 sda_m = 1'b0;
    #30 scl = 1'b0;
    #30;
  endtask
  // stop: data rises while clock high
  task stop();
    sda_m = 1'b0;
    #30 scl = 1'b1;
    #30 sda_m = 1'b1;
    #30;
  endtask
  // one 125 ns clock pulse, data changed only while low
  task pulse(input logic b, output logic s);
    sda_m = b;
    #31 scl = 1'b1;
    #31 s = sda;
    #32 scl = 1'b0;
    #31;
  endtask
  // byte MSB first, then ninth pulse; last=1 releases the line
  task xbyte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(tx[i], s);
      rx[i] = s;
    end
    pulse(last, s);
    ack = ~s;
  endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the map address select block
`timescale 1ns/1ps
module tb;
  import mas_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b1;
  logic strap = 1'b0;
  logic scl, sda_m, sda_w, sda_oe, sda_o, low_bit, wr_stb;
  logic [7:0] map_en, wr_sub, wr_data, rx;
  logic [3:0] acks;
  mas_map_e wr_sel;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int stb_n = 0;
  // pull-up wins unless the master or the device pulls low
  assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
  mas_i2c_master master_i (.scl(scl), .sda_m(sda_m), .sda(sda_w));
  mas_addr_select mas_addr_select_i (
    .SYS_CLK(sys_clk), .NRST(nrst), .SCL(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .VSYNC_STRAP_PIN(strap), .CONTROL_ADDR_LOW_BIT(low_bit),
    .MAP_ENABLED(map_en), .MAP_WR_STB(wr_stb), .MAP_WR_SEL(wr_sel),
    .MAP_WR_SUBADDR(wr_sub), .MAP_WR_DATA(wr_data));
  always #50 sys_clk = ~sys_clk;
  // strobe count and hang guard
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) stb_n++;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results();
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // write up to two bytes; acks holds addr, sub, data0, data1
  task wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d0,
          input logic [7:0] d1, input int nd);
    acks = 4'h0;
    master_i.start();
    master_i.xbyte(dev, 1'b1, rx, acks[0]);
    master_i.xbyte(sub, 1'b1, rx, acks[1]);
    if (nd > 0) master_i.xbyte(d0, 1'b1, rx, acks[2]);
    if (nd > 1) master_i.xbyte(d1, 1'b1, rx, acks[3]);
    master_i.stop();
    repeat (8) @(posedge sys_clk);
  endtask
  // set pointer, repeated start, read one byte with master nack
  task rd(input logic [7:0] dev, input logic [7:0] sub, output logic [7:0] d);
    logic a;
    master_i.start();
    master_i.xbyte(dev, 1'b1, rx, a);
    master_i.xbyte(sub, 1'b1, rx, a);
    master_i.start();
    master_i.xbyte(dev | 8'h01, 1'b1, rx, a);
    master_i.xbyte(8'hff, 1'b1, d, a);
    master_i.stop();
  endtask
  task t_reset();
    logic [7:0] d;
    chk(map_en, 8'h01);
    chk({7'h0, low_bit}, 8'h00);
    wr(8'h9a, SUB_STRAP_SAMPLE, 8'h00, 8'h00, 0);
    chk({7'h0, acks[0]}, 8'h00);
    rd(8'h98, SUB_CONSUMER_CTRL, d);
    chk(d, 8'h00);
  endtask
  // program every programmable map, read it back, then write two bytes into it
  task t_maps();
    logic [7:0] dev;
    logic [7:0] d;
    int s0;
    for (int n = 1; n < MAP_COUNT; n++) begin
      dev = 8'h60 + 8'(2 * n);
      wr(8'h98, MAP_SUB_OFS[n], dev, 8'h00, 1);
      chk({4'h0, acks}, 8'h07);
      chk({7'h0, map_en[n]}, 8'h01);
      rd(8'h98, MAP_SUB_OFS[n], d);
      chk(d, dev);
      s0 = stb_n;
      wr(dev, 8'h10, 8'ha0, 8'h5a, 2);
      chk({4'h0, acks}, 8'h0f);
      chk(8'(stb_n - s0), 8'h02);
      chk({5'h0, wr_sel}, 8'(n));
      chk(wr_sub, 8'h11);
      chk(wr_data, 8'h5a);
    end
  endtask
  // disable a map, run past the top subaddress, bad control subaddress
  task t_edges();
    int s0;
    wr(8'h98, SUB_REPEATER, 8'h00, 8'h00, 1);
    chk({7'h0, map_en[4]}, 8'h00);
    wr(8'h68, 8'h00, 8'h00, 8'h00, 0);
    chk({7'h0, acks[0]}, 8'h00);
    s0 = stb_n;
    wr(8'h6e, 8'hff, 8'h11, 8'h22, 2);
    chk({4'h0, acks}, 8'h07);
    chk(8'(stb_n - s0), 8'h01);
    chk(wr_data, 8'h11);
    wr(8'h98, 8'h20, 8'h55, 8'h00, 1);
    chk({4'h0, acks}, 8'h01);
  endtask
  task t_strap();
    @(posedge sys_clk);
    #1 strap = 1'b1;
    wr(8'h98, SUB_STRAP_SAMPLE, 8'h01, 8'h00, 1);
    chk({7'h0, low_bit}, 8'h01);
    wr(8'h98, SUB_STRAP_SAMPLE, 8'h00, 8'h00, 0);
    chk({7'h0, acks[0]}, 8'h00);
    wr(8'h9a, SUB_STRAP_SAMPLE, 8'h00, 8'h00, 1);
    chk({4'h0, acks}, 8'h07);
    @(posedge sys_clk);
    #1 strap = 1'b0;
    repeat (8) @(posedge sys_clk);
    chk({7'h0, low_bit}, 8'h01);
    wr(8'h9a, SUB_STRAP_SAMPLE, 8'h01, 8'h00, 1);
    chk({7'h0, low_bit}, 8'h00);
    wr(8'h98, SUB_STRAP_SAMPLE, 8'h00, 8'h00, 1);
    chk({4'h0, acks}, 8'h07);
  endtask
  // a real falling reset edge, so the link-side flops with async reset clear
  initial begin
    #1 nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_maps();
    t_edges();
    t_strap();
    results();
  end
endmodule
bind mas_addr_select mas_addr_select_sva mas_addr_select_sva_i (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
  .VSYNC_STRAP_PIN(VSYNC_STRAP_PIN), .CONTROL_ADDR_LOW_BIT(CONTROL_ADDR_LOW_BIT),
  .MAP_ENABLED(MAP_ENABLED), .MAP_WR_STB(MAP_WR_STB), .MAP_WR_SEL(MAP_WR_SEL),
  .MAP_WR_SUBADDR(MAP_WR_SUBADDR), .MAP_WR_DATA(MAP_WR_DATA));
